/* shared/efh_defines.vh */
// Constants for the error flag and halt-on-error block.
`ifndef EFH_DEFINES_VH
`define EFH_DEFINES_VH
// ===========================================================================
// Register offsets (word addresses on the plain register port)
`define EFH_ADDR_CTRL     4'h0
`define EFH_ADDR_STATUS   4'h1
`define EFH_ADDR_IRQ_STAT 4'h2
`define EFH_ADDR_IRQ_MASK 4'h3
`define EFH_ADDR_IPTR     4'h4
// ===========================================================================
// Field positions
`define EFH_CTRL_ERROR    0
`define EFH_CTRL_STOPF    1
`define EFH_ST_HALTED     2
`define EFH_ST_SAVED      3
`define EFH_ST_CAUSE      4
`define EFH_IRQ_ERR_RISE  0
`define EFH_IRQ_HALT      1
`define EFH_IRQ_WIDTH     2
// ===========================================================================
// Reset values and instruction pointer offsets
`define EFH_IRQ_MASK_RST  2'h0
`define EFH_ERR_IP_OFFS   16'h0002
`define EFH_FRZ_IP_OFFS   16'h0001
`endif

/* hw/efh_error_halt.v */
// Error flag, halt-on-error and freeze halt control of the processor core.
//
// The plain strobed port and the placing of the registers were decided locally.
`timescale 1ns/1ns
`include "efh_defines.vh"

module efh_error_halt #(
	parameter IPW = 16
) (
	input  wire           CLOCK,
	input  wire           NRST,
	input  wire           CORE_RESET,
	input  wire           INSTR_DONE,
	input  wire [IPW-1:0] INSTR_ADDR,
	input  wire           OVERFLOW,
	input  wire           DIV_ZERO,
	input  wire           BOUNDS_FAULT,
	input  wire           SW_SET_ERROR,
	input  wire           SW_SET_STOPF,
	input  wire           TEST_ERROR,
	input  wire           STOP_ON_ERROR,
	input  wire           PREEMPT_START,
	input  wire           PREEMPT_END,
	input  wire           DESCHED_POINT,
	input  wire           FREEZE,
	input  wire           LINKS_BUSY,
	input  wire [3:0]     REG_ADDR,
	input  wire [15:0]    REG_WDATA,
	input  wire           REG_WR,
	input  wire           REG_RD,
	output reg  [15:0]    REG_RDATA,
	output reg            ERROR,
	output reg            STOP_WHEN_FAULTED_FLAG,
	output reg            HALTED,
	output reg            PROCESS_STOP,
	output reg            LINK_OUT_FETCH_EN,
	output reg            LINK_SHUTDOWN,
	output reg            LOAD_TOS,
	output reg  [IPW-1:0] TOS_VALUE,
	output reg            IRQ
);
	// ===========================================================================
	// Freeze pin synchroniser
	reg                   frz_meta;
	reg                   frz_sync;
	reg                   frz_pend;
	reg                   save_err;
	reg                   save_stop;
	reg                   saved;
	reg                   cause_frz;
	reg [1:0]             irq_stat;
	reg [1:0]             irq_mask;
	reg [IPW-1:0]         iptr;
	reg                   next_error;
	reg                   next_stop;
	reg                   err_halt;
	reg [1:0]             ev;
	wire                  fault;
	wire                  sw_err;
	wire                  sw_stop;
	always @(posedge CLOCK or negedge NRST) begin
		if (!NRST) begin
			frz_meta <= 1'b0;
			frz_sync <= 1'b0;
		end else begin
			frz_meta <= FREEZE;
			frz_sync <= frz_meta;
		end
	end

	// ===========================================================================
	// Flag next state
	assign fault      = INSTR_DONE & (OVERFLOW | DIV_ZERO | BOUNDS_FAULT | SW_SET_ERROR);
	assign sw_err     = REG_WR && REG_ADDR == `EFH_ADDR_CTRL && REG_WDATA[`EFH_CTRL_ERROR];
	assign sw_stop    = REG_WR && REG_ADDR == `EFH_ADDR_CTRL && REG_WDATA[`EFH_CTRL_STOPF];
	always @* begin
		next_error = ERROR;
		next_stop  = STOP_WHEN_FAULTED_FLAG;
		if (PREEMPT_END && saved) begin
			next_error = save_err;
			next_stop  = save_stop;
		end else if (PREEMPT_START) begin
			next_stop = 1'b0;
		end
		if (TEST_ERROR & INSTR_DONE)
			next_error = 1'b0;
		if (fault | sw_err)
			next_error = 1'b1;
		if ((SW_SET_STOPF & INSTR_DONE) | sw_stop)
			next_stop = 1'b1;
		// Only a zero-to-one edge halts; a stop flag raised late sees no edge.
		err_halt = next_error & ~ERROR & STOP_WHEN_FAULTED_FLAG & ~HALTED;
		ev       = 2'b00;
		ev[`EFH_IRQ_ERR_RISE] = next_error & ~ERROR;
		ev[`EFH_IRQ_HALT]     = err_halt | (frz_pend & DESCHED_POINT & ~HALTED);
	end

	// ===========================================================================
	// Flags: no reset term at all, so neither processor reset nor freeze touches them.
	always @(posedge CLOCK) begin
		ERROR                  <= next_error;
		STOP_WHEN_FAULTED_FLAG <= next_stop;
	end

	// ===========================================================================
	// Pre-emption save, halt control and post-mortem pointer
	always @(posedge CLOCK or negedge NRST) begin
		if (!NRST) begin
			save_err          <= 1'b0;
			save_stop         <= 1'b0;
			saved             <= 1'b0;
			frz_pend          <= 1'b0;
			HALTED            <= 1'b0;
			cause_frz         <= 1'b0;
			iptr              <= {IPW{1'b0}};
			PROCESS_STOP      <= 1'b0;
			LINK_OUT_FETCH_EN <= 1'b1;
			LINK_SHUTDOWN     <= 1'b0;
			LOAD_TOS          <= 1'b0;
			TOS_VALUE         <= {IPW{1'b0}};
		end else begin
			LOAD_TOS <= 1'b0;
			if (PREEMPT_START && !saved) begin
				save_err  <= ERROR;
				save_stop <= STOP_WHEN_FAULTED_FLAG;
				saved     <= 1'b1;
			end else if (PREEMPT_END) begin
				saved <= 1'b0;
			end
			PROCESS_STOP <= STOP_ON_ERROR & next_error;
			if (CORE_RESET) begin
				HALTED   <= 1'b0;
				frz_pend <= 1'b0;
			end else if (err_halt) begin
				HALTED    <= 1'b1;
				cause_frz <= 1'b0;
				iptr      <= INSTR_ADDR + `EFH_ERR_IP_OFFS;
				TOS_VALUE <= INSTR_ADDR + `EFH_ERR_IP_OFFS;
				LOAD_TOS  <= 1'b1;
			end else if (frz_pend && DESCHED_POINT && !HALTED) begin
				HALTED    <= 1'b1;
				cause_frz <= 1'b1;
				frz_pend  <= 1'b0;
				iptr      <= INSTR_ADDR + `EFH_FRZ_IP_OFFS;
				TOS_VALUE <= INSTR_ADDR + `EFH_FRZ_IP_OFFS;
				LOAD_TOS  <= 1'b1;
			end else if (frz_sync && !HALTED) begin
				frz_pend <= 1'b1;
			end
			// Outputs stop fetching under freeze; inputs are never gated here.
			LINK_OUT_FETCH_EN <= ~frz_sync & ~(HALTED & ~cause_frz);
			LINK_SHUTDOWN     <= HALTED & ~LINKS_BUSY;
		end
	end

	// ===========================================================================
	// Interrupt status, mask and register port
	always @(posedge CLOCK or negedge NRST) begin
		if (!NRST) begin
			irq_stat  <= 2'b00;
			irq_mask  <= `EFH_IRQ_MASK_RST;
			IRQ       <= 1'b0;
			REG_RDATA <= 16'h0000;
		end else begin
			// A new event wins over a write-one-to-clear in the same cycle.
			if (REG_WR && REG_ADDR == `EFH_ADDR_IRQ_STAT)
				irq_stat <= (irq_stat & ~REG_WDATA[1:0]) | ev;
			else
				irq_stat <= irq_stat | ev;
			if (REG_WR && REG_ADDR == `EFH_ADDR_IRQ_MASK)
				irq_mask <= REG_WDATA[1:0];
			IRQ <= |(irq_stat & irq_mask);
			REG_RDATA <= 16'h0000;
			if (REG_RD) begin
				case (REG_ADDR)
				`EFH_ADDR_CTRL:     REG_RDATA <= {14'h0000, STOP_WHEN_FAULTED_FLAG, ERROR};
				`EFH_ADDR_STATUS:   REG_RDATA <= {11'h000, cause_frz, saved, HALTED,
				                                  STOP_WHEN_FAULTED_FLAG, ERROR};
				`EFH_ADDR_IRQ_STAT: REG_RDATA <= {14'h0000, irq_stat};
				`EFH_ADDR_IRQ_MASK: REG_RDATA <= {14'h0000, irq_mask};
				`EFH_ADDR_IPTR:     REG_RDATA <= iptr[15:0];
				default:            REG_RDATA <= 16'h0000;
				endcase
			end
		end
	end
endmodule // efh_error_halt

/* test/efh_checker.sv */
// Port checker of the error flag and halt block.
`timescale 1ns/1ns
module efh_checker(input logic CLOCK, NRST, CORE_RESET, INSTR_DONE, OVERFLOW, DIV_ZERO, BOUNDS_FAULT,
	SW_SET_ERROR, TEST_ERROR, PREEMPT_END, REG_WR, STOP_ON_ERROR, LINKS_BUSY, ERROR,
	STOP_WHEN_FAULTED_FLAG, HALTED, PROCESS_STOP, LINK_SHUTDOWN, LOAD_TOS);
// ==========
// Properties
default clocking @(posedge CLOCK); endclocking
default disable iff (!NRST);
wire cause = INSTR_DONE && (OVERFLOW || DIV_ZERO || BOUNDS_FAULT || SW_SET_ERROR);
sequence s_rise; $rose(ERROR) && $past(STOP_WHEN_FAULTED_FLAG); endsequence
sequence s_halt; ##[0:2] HALTED; endsequence
property p_set; cause |=> ERROR; endproperty
a_set: assert property (p_set) else $error("flag not set");
property p_keep; ERROR && !(INSTR_DONE && TEST_ERROR) && !PREEMPT_END |=> ERROR; endproperty
a_keep: assert property (p_keep) else $error("flag lost");
property p_clr; INSTR_DONE && TEST_ERROR && !cause && !REG_WR && !PREEMPT_END |=> !ERROR; endproperty
a_clr: assert property (p_clr) else $error("flag not cleared");
property p_halt; s_rise |-> s_halt; endproperty
a_halt: assert property (p_halt) else $error("no halt");
property p_hold; HALTED && !CORE_RESET |=> HALTED; endproperty
a_hold: assert property (p_hold) else $error("halt lost");
property p_tos; LOAD_TOS |-> ##[0:1] HALTED; endproperty
a_tos: assert property (p_tos) else $error("load without halt");
property p_link; LINK_SHUTDOWN |-> $past(HALTED) && !$past(LINKS_BUSY); endproperty
a_link: assert property (p_link) else $error("early link stop");
property p_pstop; PROCESS_STOP |-> ERROR && $past(STOP_ON_ERROR); endproperty
a_pstop: assert property (p_pstop) else $error("bad process stop");
endmodule // efh_checker
bind efh_error_halt efh_checker chk_i (.*);

/* test/efh_master_model.sv */
// Master processor watching the error pin.
`timescale 1ns/1ns
module efh_master_model(input logic clock, nrst, error_pin, armed, output logic external_event_request);
// ==========
// Event request
// The pin level is unknown after power-up, so edges count only once armed.
logic last;
always @(posedge clock or negedge nrst) begin
	if (!nrst) external_event_request <= 1'b0;
	else begin
		last <= error_pin;
		external_event_request <= armed && error_pin === 1'b1 && last === 1'b0;
	end
end
endmodule // efh_master_model

/* test/tb.sv */
// Self-checking testbench of the error flag and halt block.
`timescale 1ns/1ns
module tb;
// ==========
// Bench
logic CLOCK = 0, NRST = 0, cr = 0, soe = 0, fz = 0, lb = 0, wr = 0, rd = 0, rd_d = 0, arm = 0, evs = 0;
logic [9:0] c = 0;
logic [3:0] ad = 0;
logic [15:0] a = 0, wd = 0, x, rdata, tos, q[$], tq[$];
logic [31:0] r = 0;
logic err, stf, hlt, ps, fe, ls, lt, irq, ev;
integer seed = 32'hA47AEA45, error_cnt = 0, num_checks = 0, i, j;
always #50 CLOCK = ~CLOCK;
efh_error_halt efh_error_halt_i (.CLOCK(CLOCK), .NRST(NRST), .CORE_RESET(cr), .INSTR_DONE(c[9]),
	.INSTR_ADDR(a), .OVERFLOW(c[0]), .DIV_ZERO(c[1]), .BOUNDS_FAULT(c[2]), .SW_SET_ERROR(c[3]),
	.SW_SET_STOPF(c[4]), .TEST_ERROR(c[5]), .STOP_ON_ERROR(soe), .PREEMPT_START(c[6]),
	.PREEMPT_END(c[7]), .DESCHED_POINT(c[8]), .FREEZE(fz), .LINKS_BUSY(lb), .REG_ADDR(ad),
	.REG_WDATA(wd), .REG_WR(wr), .REG_RD(rd), .REG_RDATA(rdata), .ERROR(err),
	.STOP_WHEN_FAULTED_FLAG(stf), .HALTED(hlt), .PROCESS_STOP(ps), .LINK_OUT_FETCH_EN(fe),
	.LINK_SHUTDOWN(ls), .LOAD_TOS(lt), .TOS_VALUE(tos), .IRQ(irq));
efh_master_model efh_master_model_i (.clock(CLOCK), .nrst(NRST), .error_pin(err), .armed(arm),
	.external_event_request(ev));
task check(input logic [15:0] g, e);
	num_checks++;
	if (g !== e) begin
		error_cnt++;
		$display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
	end
endtask
task conclude;
	if (error_cnt == 0 && num_checks > 0) $display("Simulation passed");
	else $display("Simulation failed");
	$finish;
endtask
task op(input [9:0] k, input [15:0] y);
	@(posedge CLOCK) c <= k | 10'h200;
	a <= y;
	@(posedge CLOCK) c <= 0;
	#1;
endtask
task rg(input w, input [3:0] y, input [15:0] d);
	@(posedge CLOCK) wr <= w;
	rd <= !w;
	ad <= y;
	wd <= d;
	if (!w) q.push_back(d);
	@(posedge CLOCK) wr <= 0;
	rd <= 0;
	#1;
endtask
task wt;
	for (i = 0; i < 20 && tq.size() > 0; i++) @(posedge CLOCK);
	#1;
	if (tq.size() > 0) begin
		error_cnt++;
		conclude;
	end
endtask
// Each result is compared against the oldest note when it appears.
always @(posedge CLOCK) begin
	if (rd_d) check(rdata, q.pop_front());
	if (lt) check(tos, tq.pop_front());
	if (ev) evs <= 1;
	rd_d <= rd;
	r = $random(seed);
	lb <= r[16];
end
initial begin
	repeat (10) @(posedge CLOCK);
	NRST <= 1;
	rg(0, 4'h3, 16'h0000);
	rg(0, 4'hF, 16'h0000);
	op(10'h020, 0);
	arm = 1;
	op(10'h040, 0);
	rg(0, 4'h0, 16'h0000);
	// The flags power up unknown, so stale status bits are cleared before the interrupt checks.
	rg(1, 4'h2, 16'h0003);
	for (j = 0; j < 4; j++) begin
		rg(1, 4'h3, (j != 0) ? 16'h0003 : 16'h0000);
		op(10'h001 << j, 0);
		check(err, 1);
		rg(0, 4'h2, 16'h0001);
		check(irq, j != 0);
		rg(1, 4'h2, 16'h0001);
		op(10'h020, 0);
		check(err, 0);
		check(irq, 0);
	end
	op(10'h008, 0);
	op(10'h010, 0);
	repeat (3) @(posedge CLOCK);
	check(hlt, 0);
	soe <= 1;
	repeat (2) @(posedge CLOCK);
	check(ps, 1);
	soe <= 0;
	op(10'h020, 0);
	x = r[15:0];
	tq.push_back(x + 16'h0002);
	op(10'h002, x);
	wt;
	check(hlt, 1);
	NRST <= 0;
	@(posedge CLOCK) NRST <= 1;
	check(err, 1);
	check(stf, 1);
	cr <= 1;
	@(posedge CLOCK) cr <= 0;
	check(err, 1);
	fz <= 1;
	repeat (5) @(posedge CLOCK);
	check(fe, 0);
	check(hlt, 0);
	x = r[15:0];
	tq.push_back(x + 16'h0001);
	op(10'h100, x);
	wt;
	fz <= 0;
	op(10'h040, 0);
	check(err, 1);
	check(stf, 0);
	op(10'h020, 0);
	check(err, 0);
	op(10'h080, 0);
	check(err, 1);
	check(stf, 1);
	check(evs, 1);
	conclude;
end
endmodule // tb
